// [hw/lpi_sdram_init.sv]
`default_nettype none
module lpi_sdram_init
   import lpi_pkg::*;
#(
   parameter int unsigned DQ_W         = 16,
   parameter int unsigned COL_W        = 4,
   parameter int unsigned AUTOINIT_CYC = lpi_pkg::DAI_CYC,
   parameter logic [7:0]  MANUF_ID     = 8'hA5,  // arbitrary value
   parameter logic [7:0]  CFG4_VAL     = 8'h14
) (
   // clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              NRST,
   // command and control from the controller
   input  wire logic              CKE,
   input  wire lpi_pkg::lpi_cmd_t CMD,
   input  wire logic [DQ_W-1:0]   DQ_IN,
   input  wire logic              ZQ_RES_OK,
   // data pins
   output logic      [DQ_W-1:0]   DQ_OUT,
   output logic                   DQ_OE,
   // status
   output logic                   DEV_IDLE,
   output logic                   DAI_BUSY,
   output logic                   ZQ_BUSY
);
   import lpi_pkg::*;

   localparam int unsigned WW = CORE_BEATS * DQ_W;
   localparam int unsigned AW = 3 + COL_W;

   typedef struct packed {
      lpi_state_t       st;
      logic [CNT_W-1:0] cnt;
      logic [7:0]       mr0;
      logic [7:0]       mr1;
      logic [7:0]       mr2;
      logic [7:0]       mr3;
      logic [7:0]       open_banks;
      logic             rd_em;
      logic             rd_load;
      logic [1:0]       beat;
      logic [1:0]       rd_k;
      logic [1:0]       rd_last;
      logic             rd_bt;
      logic [2:0]       rd_ba;
      logic [COL_W-1:0] rd_w0;
      logic [WW-1:0]    buf_rd;
      logic             wr_act;
      logic [1:0]       wr_beat;
      logic [1:0]       wr_k;
      logic [1:0]       wr_last;
      logic             wr_bt;
      logic [2:0]       wr_ba;
      logic [COL_W-1:0] wr_w0;
      logic [WW-1:0]    buf_wr;
      logic [DQ_W-1:0]  dq_out;
      logic             dq_oe;
      logic             dev_idle;
      logic             dai_busy;
      logic             zq_busy;
   } lpi_st_t;

   lpi_st_t r;
   lpi_st_t nxt;

   logic          mem_wr_en;
   logic [AW-1:0] mem_wr_addr;
   logic [WW-1:0] mem_wr_data;
   logic          mem_rd_en;
   logic [AW-1:0] mem_rd_addr;
   logic [WW-1:0] mem_rd_data;
   logic          cmd_ok;
   logic          busy_xfer;
   logic [7:0]    mrr_val;

   // ======================================================================
   // burst helpers
   function automatic logic [1:0] burst_last(input logic [2:0] bl);
      logic [1:0] l;
      l = 2'd0;
      case (bl)
         BL_4:    l = 2'd0;
         BL_8:    l = 2'd1;
         BL_16:   l = 2'd3;
         default: l = 2'd0;
      endcase
      return l;
   endfunction

   // word k of a burst, wrapping inside the burst-aligned block
   function automatic logic [AW-1:0] word_addr(input logic [2:0]       ba,
                                               input logic [COL_W-1:0] w0,
                                               input logic [1:0]       k,
                                               input logic [1:0]       last,
                                               input logic             bt);
      logic [COL_W-1:0] m;
      logic [COL_W-1:0] kk;
      logic [COL_W-1:0] w;
      m  = COL_W'(last);
      kk = COL_W'(k);
      w  = bt ? (w0 ^ kk) : ((w0 & ~m) | ((w0 + kk) & m));
      return {ba, w};
   endfunction
   // ======================================================================
   // mode register read mux; unlisted addresses read as zero
   always_comb begin
      case (CMD.ma)
         MA_DEVINFO: mrr_val = r.mr0;
         MA_REFRATE: mrr_val = REFRATE_RST;
         MA_MANUF:   mrr_val = MANUF_ID;
         MA_CFG4:    mrr_val = CFG4_VAL;
         default:    mrr_val = 8'h00;
      endcase
   end
   // ======================================================================
   // next state
   always_comb begin
      nxt         = r;
      nxt.rd_load = 1'b0;
      nxt.dq_oe   = 1'b0;
      mem_wr_en   = 1'b0;
      mem_wr_addr = word_addr(r.wr_ba, r.wr_w0, r.wr_k, r.wr_last, r.wr_bt);
      mem_wr_data = r.buf_wr;
      mem_wr_data[3*DQ_W +: DQ_W] = DQ_IN;
      mem_rd_en   = 1'b0;
      mem_rd_addr = word_addr(r.rd_ba, r.rd_w0, 2'(r.rd_k + 2'd1), r.rd_last, r.rd_bt);
      // commands only register while the clock is enabled after ramp
      cmd_ok      = CKE && (r.st != ST_OFF);
      busy_xfer   = r.rd_em || r.rd_load || r.wr_act;
      // read burst: one core word feeds four pin beats
      if (r.rd_load) begin
         nxt.buf_rd = mem_rd_data;
      end
      if (r.rd_em) begin
         nxt.dq_out = r.buf_rd[r.beat*DQ_W +: DQ_W];
         nxt.dq_oe  = 1'b1;
         nxt.beat   = 2'(r.beat + 2'd1);
         // prefetch the next word so beats follow without a gap
         if (r.beat == 2'd2 && r.rd_k != r.rd_last) begin
            mem_rd_en   = 1'b1;
            nxt.rd_k    = 2'(r.rd_k + 2'd1);
            nxt.rd_load = 1'b1;
         end
         if (r.beat == 2'd3 && !r.rd_load) begin
            nxt.rd_em = 1'b0;
         end
      end else if (r.rd_load) begin
         nxt.rd_em = 1'b1;
         nxt.beat  = 2'd0;
      end
      // write burst: four pin beats gather into one core word
      if (r.wr_act) begin
         nxt.buf_wr[r.wr_beat*DQ_W +: DQ_W] = DQ_IN;
         nxt.wr_beat = 2'(r.wr_beat + 2'd1);
         if (r.wr_beat == 2'd3) begin
            mem_wr_en = 1'b1;
            nxt.wr_k  = 2'(r.wr_k + 2'd1);
            if (r.wr_k == r.wr_last) begin
               nxt.wr_act = 1'b0;
            end
         end
      end
      case (r.st)
         ST_OFF:   nxt.st = CKE ? ST_PWRUP : ST_OFF;
         // only the reset write, handled below, leaves power-up
         ST_PWRUP: nxt.st = ST_PWRUP;
         ST_DAI: begin
            if (r.cnt == '0) begin
               nxt.mr0[MR0_DAI] = 1'b0;
               nxt.st           = ST_IDLE;
            end else begin
               nxt.cnt = CNT_W'(r.cnt - 1'b1);
            end
         end
         ST_ZQ: begin
            if (r.cnt == '0) begin
               nxt.mr0[MR0_RZQ_LO +: 2] = ZQ_RES_OK ? RZQ_OK : RZQ_MISSING;
               nxt.st = ST_IDLE;
            end else begin
               nxt.cnt = CNT_W'(r.cnt - 1'b1);
            end
         end
         ST_IDLE: begin
            if (cmd_ok) begin
               case (CMD.op)
                  CMD_ACT: nxt.open_banks[CMD.ba] = 1'b1;
                  CMD_PRE: nxt.open_banks[CMD.ba] = 1'b0;
                  CMD_PREA: nxt.open_banks = 8'h00;
                  CMD_RD: begin
                     if (r.open_banks[CMD.ba] && !busy_xfer) begin
                        nxt.rd_ba   = CMD.ba;
                        nxt.rd_w0   = CMD.col[COL_W+1:2];
                        nxt.rd_k    = 2'd0;
                        nxt.rd_last = burst_last(r.mr1[MR1_BL_LO +: 3]);
                        nxt.rd_bt   = r.mr1[MR1_BT];
                        mem_rd_en   = 1'b1;
                        mem_rd_addr = word_addr(CMD.ba, CMD.col[COL_W+1:2], 2'd0,
                                                nxt.rd_last, nxt.rd_bt);
                        nxt.rd_load = 1'b1;
                     end
                  end
                  CMD_WR: begin
                     if (r.open_banks[CMD.ba] && !busy_xfer) begin
                        nxt.wr_act  = 1'b1;
                        nxt.wr_beat = 2'd0;
                        nxt.wr_k    = 2'd0;
                        nxt.wr_ba   = CMD.ba;
                        nxt.wr_w0   = CMD.col[COL_W+1:2];
                        nxt.wr_last = burst_last(r.mr1[MR1_BL_LO +: 3]);
                        nxt.wr_bt   = r.mr1[MR1_BT];
                     end
                  end
                  CMD_MRW: begin
                     // read-only registers ignore writes
                     if (CMD.ma == MA_FEAT1) begin
                        nxt.mr1 = CMD.opd;
                     end else if (CMD.ma == MA_FEAT2) begin
                        nxt.mr2 = CMD.opd;
                     end else if (CMD.ma == MA_IOCFG) begin
                        nxt.mr3 = CMD.opd;
                     end else if (CMD.ma == MA_ZQCAL && CMD.opd == OP_ZQ_INIT
                                  && !busy_xfer) begin
                        nxt.st  = ST_ZQ;
                        nxt.cnt = CNT_W'(ZQ_CYC - 1);
                     end
                  end
                  default: nxt.st = ST_IDLE;
               endcase
            end
         end
         default: nxt.st = ST_OFF;
      endcase
      // mode register read: one beat on the low lanes
      if (cmd_ok && CMD.op == CMD_MRR && !r.rd_em && !r.rd_load
          && (r.st == ST_DAI || r.st == ST_IDLE)) begin
         nxt.dq_out = DQ_W'(mrr_val);
         nxt.dq_oe  = 1'b1;
      end
      // reset write restarts from the reset step in any powered state
      if (cmd_ok && CMD.op == CMD_MRW && CMD.ma == MA_RESET) begin
         nxt.st         = ST_DAI;
         nxt.cnt        = CNT_W'(AUTOINIT_CYC - 1);
         nxt.mr0        = MR0_RST;
         nxt.mr1        = MR1_RST;
         nxt.mr2        = MR2_RST;
         nxt.mr3        = MR3_RST;
         nxt.open_banks = 8'h00;
         nxt.rd_em      = 1'b0;
         nxt.rd_load    = 1'b0;
         nxt.wr_act     = 1'b0;
         mem_wr_en      = 1'b0;
         mem_rd_en      = 1'b0;
      end
      // pins stop driving from the cycle after clock-enable is seen low
      nxt.dq_oe    = nxt.dq_oe && CKE;
      nxt.dev_idle = (nxt.st == ST_IDLE) && (nxt.open_banks == 8'h00)
                     && !nxt.rd_em && !nxt.rd_load && !nxt.wr_act;
      nxt.dai_busy = nxt.mr0[MR0_DAI];
      nxt.zq_busy  = (nxt.st == ST_ZQ);
   end
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         r     <= '0;
         r.st  <= ST_OFF;
         r.mr0 <= MR0_RST;
         r.mr1 <= MR1_RST;
         r.mr2 <= MR2_RST;
         r.mr3 <= MR3_RST;
         r.dai_busy <= 1'b1;
      end else begin
         r <= nxt;
      end
   end
   // ======================================================================
   // core array
   lpi_core_mem #(
      .W  (WW),
      .AW (AW)
   ) u_core (
      .clk     (SYS_CLK),
      .rst_n   (NRST),
      .wr_en   (mem_wr_en),
      .wr_addr (mem_wr_addr),
      .wr_data (mem_wr_data),
      .rd_en   (mem_rd_en),
      .rd_addr (mem_rd_addr),
      .rd_data (mem_rd_data)
   );
   assign DQ_OUT   = r.dq_out;
   assign DQ_OE    = r.dq_oe;
   assign DEV_IDLE = r.dev_idle;
   assign DAI_BUSY = r.dai_busy;
   assign ZQ_BUSY  = r.zq_busy;
endmodule
`default_nettype wire

// [hw/lpi_pkg.sv]
// Notes on behaviour
// - core moves one 4n word per access; pins carry four n-bit beats.
// - bursts start at the chosen column, run programmed length in programmed order.
// - the idle state implies every bank is precharged.
// - outputs are only guaranteed off while clock-enable is low; the code stops driving from the cycle after it is seen low.
// - device finishes auto-init within 10 us of reset, flags it, goes idle.
// - ZQ init write calibrates drivers, records resistor, ready after 1 us.
// - reset write outside power-up restarts init from the reset step.
// - completion flag is read by mode-register read at address 00h.
`default_nettype none
package lpi_pkg;
   // ======================================================================
   // command bus
   typedef enum logic [2:0] {
      CMD_NOP  = 3'h0,
      CMD_ACT  = 3'h1,
      CMD_RD   = 3'h2,
      CMD_WR   = 3'h3,
      CMD_PRE  = 3'h4,
      CMD_PREA = 3'h5,
      CMD_MRW  = 3'h6,
      CMD_MRR  = 3'h7
   } lpi_cmd_op_t;

   typedef struct packed {
      lpi_cmd_op_t op;
      logic [2:0]  ba;
      logic [9:0]  col;
      logic [7:0]  ma;
      logic [7:0]  opd;
   } lpi_cmd_t;

   // ======================================================================
   // device states
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_PWRUP = 3'b001,
      ST_DAI   = 3'b011,
      ST_IDLE  = 3'b010,
      ST_ZQ    = 3'b110
   } lpi_state_t;

   // ======================================================================
   // timing
   localparam int unsigned CLK_NS    = 20;
   localparam int unsigned T_DAI_NS  = 10000;
   localparam int unsigned DAI_CYC   = T_DAI_NS / CLK_NS;
   localparam int unsigned T_ZQ_NS   = 1000;
   localparam int unsigned ZQ_CYC    = (T_ZQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_W     = 10;
   localparam int unsigned CORE_BEATS = 4;

   // ======================================================================
   // mode register addresses and fields
   localparam logic [7:0] MA_DEVINFO = 8'h00;
   localparam logic [7:0] MA_FEAT1   = 8'h01;
   localparam logic [7:0] MA_FEAT2   = 8'h02;
   localparam logic [7:0] MA_IOCFG   = 8'h03;
   localparam logic [7:0] MA_REFRATE = 8'h04;
   localparam logic [7:0] MA_MANUF   = 8'h05;
   localparam logic [7:0] MA_CFG4    = 8'h08;
   localparam logic [7:0] MA_ZQCAL   = 8'h0A;
   localparam logic [7:0] MA_RESET   = 8'h3F;
   localparam logic [7:0] OP_ZQ_INIT = 8'hFF;

   localparam int unsigned MR0_DAI    = 0;
   localparam int unsigned MR0_RZQ_LO = 3;
   localparam int unsigned MR1_BL_LO  = 0;
   localparam int unsigned MR1_BT     = 3;

   localparam logic [2:0] BL_4  = 3'h2;
   localparam logic [2:0] BL_8  = 3'h3;
   localparam logic [2:0] BL_16 = 3'h4;

   localparam logic [1:0] RZQ_OK      = 2'h0;
   localparam logic [1:0] RZQ_MISSING = 2'h1;

   localparam logic [7:0] MR0_RST    = 8'h01;
   localparam logic [7:0] MR1_RST    = 8'h02;
   localparam logic [7:0] MR2_RST    = 8'h01;
   localparam logic [7:0] MR3_RST    = 8'h02;
   localparam logic [7:0] REFRATE_RST = 8'h03;
endpackage
`default_nettype wire

// [hw/lpi_core_mem.sv]
`default_nettype none
module lpi_core_mem #(
   parameter int unsigned W  = 64,
   parameter int unsigned AW = 7
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   // read side
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);
   typedef struct packed {
      logic [(1<<AW)-1:0][W-1:0] mem;
      logic [W-1:0]              rdata;
   } lpi_mem_st_t;

   lpi_mem_st_t r;
   lpi_mem_st_t nxt;

   always_comb begin
      nxt = r;
      if (wr_en) begin
         nxt.mem[wr_addr] = wr_data;
      end
      if (rd_en) begin
         nxt.rdata = r.mem[rd_addr];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign rd_data = r.rdata;
endmodule
`default_nettype wire

// [test/lpi_sdram_init_sva.sv]
`default_nettype none
module lpi_sdram_init_sva
   import lpi_pkg::*;
#(
   parameter int unsigned DQ_W         = 16,
   parameter int unsigned AUTOINIT_CYC = 8
) (
   // clock and reset
   input wire logic              SYS_CLK,
   input wire logic              NRST,
   // controller side
   input wire logic              CKE,
   input wire lpi_pkg::lpi_cmd_t CMD,
   input wire logic [DQ_W-1:0]   DQ_IN,
   input wire logic              ZQ_RES_OK,
   // device side
   input wire logic [DQ_W-1:0]   DQ_OUT,
   input wire logic              DQ_OE,
   input wire logic              DEV_IDLE,
   input wire logic              DAI_BUSY,
   input wire logic              ZQ_BUSY
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AIM     = AUTOINIT_CYC - 1;
   localparam int ZQ_HOLD = ZQ_CYC - 1;
   logic          rst_cmd;
   logic          zq_cmd;
   logic          mrr0_cmd;

   // ======================================================================
   // command decode
   assign rst_cmd  = CKE && CMD.op == CMD_MRW && CMD.ma == MA_RESET;
   assign zq_cmd   = DEV_IDLE && CKE && CMD.op == CMD_MRW && CMD.ma == MA_ZQCAL
                     && CMD.opd == OP_ZQ_INIT;
   assign mrr0_cmd = DEV_IDLE && CKE && CMD.op == CMD_MRR && CMD.ma == MA_DEVINFO;

   // ======================================================================
   // properties
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   a_reset_state: assert property (
      NRST && !$past(NRST) |-> DAI_BUSY && !DEV_IDLE && !ZQ_BUSY && !DQ_OE)
      else $error("status outputs wrong after reset");
   a_dq_off_cke: assert property (
      !CKE |=> !DQ_OE)
      else $error("data driven after clock enable low");
   // a past edge with clock enable high means the device has left OFF
   a_dai_window: assert property (
      $past(NRST) && $past(CKE) && rst_cmd
      |=> (DAI_BUSY && !DEV_IDLE) ##AIM DAI_BUSY ##1 (!DAI_BUSY && DEV_IDLE))
      else $error("auto-init window wrong");
   a_zq_time: assert property (
      zq_cmd |=> ZQ_BUSY ##ZQ_HOLD ZQ_BUSY ##1 !ZQ_BUSY)
      else $error("calibration time wrong");
   a_mrr_done: assert property (
      mrr0_cmd |=> DQ_OE && !DQ_OUT[MR0_DAI] && DQ_OUT[DQ_W-1:8] == '0)
      else $error("device info read wrong");
   a_act_leaves: assert property (
      DEV_IDLE && CKE && CMD.op == CMD_ACT |=> !DEV_IDLE)
      else $error("idle with a bank open");
   a_busy_not_idle: assert property (
      DAI_BUSY || ZQ_BUSY |-> !DEV_IDLE)
      else $error("idle while busy");
   a_zq_after_dai: assert property (
      ZQ_BUSY |-> !DAI_BUSY)
      else $error("calibration during auto-init");

   c_reset_cmd: cover property (rst_cmd);
   c_zq_cmd: cover property (zq_cmd);
   c_mrr_done: cover property (mrr0_cmd);
   c_cke_low: cover property (!CKE ##1 !CKE);
endmodule
`default_nettype wire

// [test/lpi_ctl_model.sv]
`default_nettype none
module lpi_ctl_model
   import lpi_pkg::*;
#(
   parameter int unsigned CKE_LOW_CYC = (100 + CLK_NS - 1) / CLK_NS + 5,
   parameter int unsigned INIT3_CYC   = (200000 + CLK_NS - 1) / CLK_NS,
   parameter int unsigned INIT4_CYC   = (1000 + CLK_NS - 1) / CLK_NS
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // bench control
   input  wire logic         restart,
   output logic              ready,
   // device pins
   input  wire logic [7:0]   dq_lo,
   output logic              cke,
   output lpi_pkg::lpi_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ns;

   task automatic issue(input lpi_cmd_op_t op, input logic [7:0] ma, input logic [7:0] opd);
      cmd = '{op: op, ba: 3'h0, col: 10'h000, ma: ma, opd: opd};
      @(negedge clk);
      // fields are don't-care under NOP, so scramble them
      cmd = {CMD_NOP, ~cmd[28:0]};
   endtask

   task automatic boot(input logic first);
      int   n;
      logic busy;
      issue(CMD_MRW, MA_RESET, 8'h00);
      repeat (INIT4_CYC) @(negedge clk);
      n    = 0;
      busy = 1'b1;
      while (busy && n < 1000) begin
         issue(CMD_MRR, MA_DEVINFO, 8'h00);
         busy = dq_lo[MR0_DAI];
         n++;
         if (first && n == 2) begin
            cke = 1'b0;
            repeat (3) @(negedge clk);
            cke = 1'b1;
         end
      end
      issue(CMD_MRR, MA_MANUF, 8'h00);
      issue(CMD_MRR, MA_CFG4, 8'h00);
      issue(CMD_MRW, MA_ZQCAL, OP_ZQ_INIT);
      repeat (ZQ_CYC + 1) @(negedge clk);
      issue(CMD_MRW, MA_FEAT1, MR1_RST);
      issue(CMD_MRW, MA_FEAT2, MR2_RST);
      issue(CMD_MRW, MA_IOCFG, MR3_RST);
   endtask

   initial begin
      cke   = 1'b0;                           // low while supplies ramp or fall
      cmd   = '0;
      ready = 1'b0;
      @(negedge clk);
      wait (rst_n);
      repeat (CKE_LOW_CYC) @(negedge clk);    // clock runs meanwhile
      cke = 1'b1;
      repeat (INIT3_CYC) @(negedge clk);
      boot(1'b1);
      ready = 1'b1;
      forever begin
         @(negedge clk);
         if (restart) begin
            ready = 1'b0;
            boot(1'b0);
            ready = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [test/tb_sdram_power_up_init_sequence.sv]
`default_nettype none
module tb_sdram_power_up_init_sequence
   import lpi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned DQ_W = 16;
   localparam int unsigned AI   = 120;
   logic                   sys_clk = 1'b0;
   logic                   nrst    = 1'b0;
   logic                   m_cke, t_cke, cke, ready, restart, zq_res_ok;
   logic                   dq_oe, dev_idle, dai_busy, zq_busy;
   lpi_cmd_t               m_cmd, t_cmd, cmd;
   logic [DQ_W-1:0]        dq_in, dq_out;
   logic [63:0]            ref_mem [0:15];
   logic [31:0]            seed    = 32'hcae9_d625;
   int                     n_fail  = 0;
   int                     checked = 0;

   // fixed 20 ns period, inside the boot range
   always #10 sys_clk = ~sys_clk;
   assign cmd = ready ? t_cmd : m_cmd;
   assign cke = ready ? t_cke : m_cke;

   lpi_sdram_init #(.DQ_W(DQ_W), .COL_W(4), .AUTOINIT_CYC(AI)) u_dut (
      .SYS_CLK(sys_clk), .NRST(nrst), .CKE(cke), .CMD(cmd), .DQ_IN(dq_in),
      .ZQ_RES_OK(zq_res_ok), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .DEV_IDLE(dev_idle),
      .DAI_BUSY(dai_busy), .ZQ_BUSY(zq_busy));
   lpi_ctl_model u_ctl (.clk(sys_clk), .rst_n(nrst), .restart(restart), .ready(ready),
      .dq_lo(dq_out[7:0]), .cke(m_cke), .cmd(m_cmd));

   // ======================================================================
   // helpers
   function automatic logic [3:0] word_at(input logic [3:0] w0, input int k, input int len,
                                          input logic bt);
      logic [3:0] m;
      m = 4'(len - 1);
      return (w0 & ~m) | ((bt ? (w0 ^ 4'(k)) : (w0 + 4'(k))) & m);
   endfunction
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic cmp_val(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_val(DQ_W'(got), DQ_W'(exp));
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic send(input lpi_cmd_op_t op, input logic [9:0] col, input logic [7:0] ma,
                       input logic [7:0] opd);
      t_cmd = '{op: op, ba: 3'h5, col: col, ma: ma, opd: opd};
      @(negedge sys_clk);
      t_cmd = {CMD_NOP, ~t_cmd[28:0]};
   endtask
   task automatic mrr(input logic [7:0] ma, input logic [7:0] exp);
      send(CMD_MRR, 10'h000, ma, 8'h00);
      cmp_bit(dq_oe, 1'b1);
      cmp_val(dq_out, {8'h00, exp});
      @(negedge sys_clk);
      cmp_bit(dq_oe, 1'b0);
   endtask
   task automatic wr(input logic [9:0] col, input int len, input logic bt);
      logic [31:0] a, b;
      logic [3:0]  w;
      send(CMD_WR, col, 8'h00, 8'h00);
      for (int k = 0; k < len; k++) begin
         a = rnd();
         b = rnd();
         w          = word_at(col[5:2], k, len, bt);
         ref_mem[w] = {b, a};
         for (int i = 0; i < 4; i++) begin
            dq_in = ref_mem[w][i*16 +: 16];
            @(negedge sys_clk);
         end
      end
      dq_in = ~dq_in;
   endtask
   task automatic rd(input logic [9:0] col, input int len, input logic bt);
      logic [63:0] e;
      send(CMD_RD, col, 8'h00, 8'h00);
      @(negedge sys_clk);
      for (int k = 0; k < len; k++) begin
         e = ref_mem[word_at(col[5:2], k, len, bt)];
         for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            cmp_bit(dq_oe, 1'b1);
            cmp_val(dq_out, e[i*16 +: 16]);
         end
      end
      @(negedge sys_clk);
      cmp_bit(dq_oe, 1'b0);
   endtask

   // ======================================================================
   // main sequence
   initial begin
      logic [31:0] r;
      logic [2:0]  bl;
      logic        bt;
      t_cmd     = '0;
      t_cke     = 1'b1;
      dq_in     = '0;
      zq_res_ok = 1'b1;
      restart   = 1'b0;
      repeat (20) @(negedge sys_clk);
      cmp_bit(dai_busy, 1'b1);
      cmp_bit(dq_oe, 1'b0);
      nrst = 1'b1;
      wait (ready);
      @(negedge sys_clk);
      cmp_bit(dev_idle, 1'b1);
      mrr(MA_DEVINFO, {3'h0, RZQ_OK, 3'h0});
      // a write to the read-only info register must leave it alone
      send(CMD_MRW, 10'h000, MA_DEVINFO, 8'hFF);
      mrr(MA_DEVINFO, {3'h0, RZQ_OK, 3'h0});
      mrr(MA_REFRATE, REFRATE_RST);
      send(CMD_ACT, 10'h000, 8'h00, 8'h00);
      send(CMD_MRW, 10'h000, MA_FEAT1, {5'h00, BL_16});
      for (int w = 0; w < 4; w++) wr(10'(w * 16), 4, 1'b0);
      for (int i = 0; i < 12; i++) begin
         bl = (i % 3 == 0) ? BL_4 : (i % 3 == 1) ? BL_8 : BL_16;
         bt = (i % 6) >= 3;
         send(CMD_MRW, 10'h000, MA_FEAT1, {4'h0, bt, bl});
         r = rnd();
         wr(r[9:0] & 10'h03F, 1 << (i % 3), bt);
         rd(r[25:16] & 10'h03F, 1 << (i % 3), bt);
      end
      send(CMD_PREA, 10'h000, 8'h00, 8'h00);
      @(negedge sys_clk);
      cmp_bit(dev_idle, 1'b1);
      cmp_bit(zq_busy, 1'b0);
      // a second calibration from idle is accepted and times out alike
      send(CMD_MRW, 10'h000, MA_ZQCAL, OP_ZQ_INIT);
      cmp_bit(zq_busy, 1'b1);
      cmp_bit(dev_idle, 1'b0);
      repeat (ZQ_CYC - 1) @(negedge sys_clk);
      cmp_bit(zq_busy, 1'b1);
      @(negedge sys_clk);
      cmp_bit(zq_busy, 1'b0);
      cmp_bit(dev_idle, 1'b1);
      zq_res_ok = 1'b0;
      restart   = 1'b1;
      wait (!ready);
      restart = 1'b0;
      wait (ready);
      @(negedge sys_clk);
      mrr(MA_DEVINFO, {3'h0, RZQ_MISSING, 3'h0});
      report_and_stop();
   end

   // whole run needs about 11000 cycles
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end
endmodule

bind lpi_sdram_init lpi_sdram_init_sva #(.DQ_W(DQ_W), .AUTOINIT_CYC(AUTOINIT_CYC)) u_sva (
   .SYS_CLK(SYS_CLK), .NRST(NRST), .CKE(CKE), .CMD(CMD), .DQ_IN(DQ_IN),
   .ZQ_RES_OK(ZQ_RES_OK), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DEV_IDLE(DEV_IDLE),
   .DAI_BUSY(DAI_BUSY), .ZQ_BUSY(ZQ_BUSY));
`default_nettype wire
